// File: inc/sec_map.vh
// Register map, field positions and timing for the serial ROM controller.
// Assumes a 10 MHz system clock and a three-wire serial EEPROM on the far side.
`ifndef SEC_MAP_VH
`define SEC_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SEC_OFS_CMD 8'hB0
`define SEC_OFS_DATA 8'hB4
`define SEC_OFS_ISTS 8'hB8
`define SEC_OFS_IMSK 8'hBC

// ----------------------------------------------------------------------
// Command register and interrupt status register fields
// ----------------------------------------------------------------------
`define SEC_BUSY_BIT 31
`define SEC_OP_HI 30
`define SEC_OP_LO 28
`define SEC_TMO_BIT 9
`define SEC_LOADED_BIT 8
`define SEC_ISTS_DONE 0
`define SEC_ISTS_TMO 1
`define SEC_ISTS_LOADED 2

// ----------------------------------------------------------------------
// Command codes and serial opcodes
// ----------------------------------------------------------------------
`define SEC_OP_READ 3'h0
`define SEC_OP_WR_DIS 3'h1
`define SEC_OP_WR_EN 3'h2
`define SEC_OP_WRITE 3'h3
`define SEC_OP_WR_ALL 3'h4
`define SEC_OP_ERASE 3'h5
`define SEC_OP_ERASE_ALL 3'h6
`define SEC_OP_RELOAD 3'h7
`define SEC_SER_READ 2'h2
`define SEC_SER_WRITE 2'h1
`define SEC_SER_ERASE 2'h3
`define SEC_SER_EXT 2'h0
`define SEC_EXT_WR_DIS 8'h00
`define SEC_EXT_WR_ALL 8'h40
`define SEC_EXT_ERASE_ALL 8'h80
`define SEC_EXT_WR_EN 8'hC0
`define SEC_SIGNATURE 8'hA5
`define SEC_MAC_LAST 3'h6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SEC_CLK_KHZ 10000
`define SEC_SK_HALF_NS 500
`define SEC_SK_HALF_CYC ((`SEC_SK_HALF_NS * `SEC_CLK_KHZ) / 1000000)
`define SEC_TMO_MS 30
`define SEC_TMO_CYC (`SEC_TMO_MS * `SEC_CLK_KHZ)

`endif

// File: hdl/sec_wire.v
// Serial shifter: one framed transaction on the three-wire EEPROM link.
// Assumes the frame is left aligned with its start bit in bit 18.
`include "sec_map.vh"

module sec_wire #(
  parameter TMO_CYC = `SEC_TMO_CYC
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // Request
  input wire start,
  input wire [18:0] frame,
  input wire [4:0] nbits,
  input wire rd,
  input wire poll,
  // Answer
  output reg done_q,
  output reg tmo_q,
  output reg [7:0] rdata_q,
  // Link pins
  output reg cs_q,
  output reg sk_q,
  output wire dio_o,
  output reg dio_oe_q,
  input wire dio_i
);

  localparam W_IDLE = 3'd0;
  localparam W_SEND = 3'd1;
  localparam W_RECV = 3'd2;
  localparam W_GAP = 3'd3;
  localparam W_POLL = 3'd4;
  // Integer counts cut to the counter widths on purpose
  localparam [31:0] HALF_W = `SEC_SK_HALF_CYC;
  localparam [31:0] TMO_END_W = TMO_CYC - 1;
  localparam [7:0] HALF = HALF_W[7:0];
  localparam [18:0] TMO_END = TMO_END_W[18:0];

  reg [2:0] st_q;
  reg [7:0] div_q;
  reg [4:0] cnt_q;
  reg [18:0] frm_q;
  reg [18:0] tmo_cnt_q;
  reg rd_q;
  reg poll_q;
  wire tick;

  assign tick = (div_q == HALF - 8'h01);
  // Frame shifts out MSB first straight from the register
  assign dio_o = frm_q[18];

  // ----------------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= W_IDLE;
      div_q <= 8'h00;
      cnt_q <= 5'h00;
      frm_q <= 19'h0;
      tmo_cnt_q <= 19'h0;
      rd_q <= 1'b0;
      poll_q <= 1'b0;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      rdata_q <= 8'h00;
      cs_q <= 1'b0;
      sk_q <= 1'b0;
      dio_oe_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      div_q <= (tick || st_q == W_IDLE) ? 8'h00 : div_q + 8'h01;
      case (st_q)
        W_IDLE: begin
          if (start) begin
            frm_q <= frame;
            cnt_q <= nbits;
            rd_q <= rd;
            poll_q <= poll;
            cs_q <= 1'b1;
            dio_oe_q <= 1'b1;
            st_q <= W_SEND;
          end
        end
        W_SEND: begin
          // Slave samples on the rising clock, we shift after falling
          if (tick) begin
            sk_q <= ~sk_q;
            if (sk_q) begin
              frm_q <= {frm_q[17:0], 1'b0};
              cnt_q <= cnt_q - 5'h01;
              if (cnt_q == 5'h01) begin
                dio_oe_q <= 1'b0;
                if (rd_q) begin
                  cnt_q <= 5'h08;
                  st_q <= W_RECV;
                end else begin
                  cs_q <= 1'b0;
                  if (poll_q) begin
                    st_q <= W_GAP;
                  end else begin
                    done_q <= 1'b1;
                    st_q <= W_IDLE;
                  end
                end
              end
            end
          end
        end
        W_RECV: begin
          if (tick) begin
            sk_q <= ~sk_q;
            if (sk_q) begin
              rdata_q <= {rdata_q[6:0], dio_i};
              cnt_q <= cnt_q - 5'h01;
              if (cnt_q == 5'h01) begin
                cs_q <= 1'b0;
                done_q <= 1'b1;
                st_q <= W_IDLE;
              end
            end
          end
        end
        W_GAP: begin
          // Chip select low for one half period starts the ready check
          if (tick) begin
            cs_q <= 1'b1;
            tmo_cnt_q <= 19'h0;
            st_q <= W_POLL;
          end
        end
        W_POLL: begin
          // A pulled-high data pin with no part present completes at once
          tmo_cnt_q <= tmo_cnt_q + 19'h1;
          if (dio_i || tmo_cnt_q == TMO_END) begin
            cs_q <= 1'b0;
            done_q <= 1'b1;
            tmo_q <= ~dio_i;
            st_q <= W_IDLE;
          end
        end
        default: st_q <= W_IDLE;
      endcase
    end
  end

endmodule // sec_wire

// File: hdl/sec_ctrl.v
// Serial ROM controller: command/data registers on classic Wishbone,
// command sequencing, MAC address load at reset and on request.
// Assumes a three-wire serial EEPROM whose data pin is resolved outside.
//
// The Wishbone slave port was decided locally.
`include "sec_map.vh"

module sec_ctrl #(
  parameter TMO_CYC = `SEC_TMO_CYC
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Interrupt
  output reg irq_q,
  // Serial ROM link
  output wire rom_cs,
  output wire rom_clk,
  output wire serial_rom_data_pin_o,
  output wire serial_rom_data_pin_oe,
  input wire serial_rom_data_pin_i,
  // Loaded station address
  output reg [47:0] mac_addr_q
);

  localparam M_IDLE = 2'd0;
  localparam M_GO = 2'd1;
  localparam M_WAIT = 2'd2;

  reg [1:0] st_q;
  reg busy_q;
  reg [2:0] op_q;
  reg [7:0] addr_q;
  reg [7:0] data_q;
  reg tmo_flag_q;
  reg loaded_q;
  reg reload_q;
  reg [2:0] idx_q;
  reg [2:0] ists_q;
  reg [2:0] imsk_q;

  // Bus decode
  wire req;
  wire wr;
  wire hit_cmd;
  wire hit_data;
  wire hit_ists;
  wire hit_imsk;
  reg [31:0] rd_mux;

  // Link request
  reg [18:0] frame;
  reg [4:0] nbits;
  reg rd;
  reg poll;
  wire w_start;
  wire w_done;
  wire w_tmo;
  wire [7:0] w_rdata;

  // Events for flags
  wire ev_done;
  wire ev_loaded;
  wire sig_bad;

  // Host writes to the op and address bits land only while idle; flag clears land even while busy
  wire cmd_wr;
  wire go_wr;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign hit_cmd = (wb_adr_i[7:2] == `SEC_OFS_CMD >> 2);
  assign hit_data = (wb_adr_i[7:2] == `SEC_OFS_DATA >> 2);
  assign hit_ists = (wb_adr_i[7:2] == `SEC_OFS_ISTS >> 2);
  assign hit_imsk = (wb_adr_i[7:2] == `SEC_OFS_IMSK >> 2);
  assign cmd_wr = wr && hit_cmd && !busy_q;
  assign go_wr = cmd_wr && wb_sel_i[3] && wb_dat_i[`SEC_BUSY_BIT];
  assign w_start = (st_q == M_GO);
  assign sig_bad = (idx_q == 3'h0) && (w_rdata != `SEC_SIGNATURE);
  assign ev_done = (st_q == M_WAIT) && w_done && (!reload_q || sig_bad ||
                   idx_q == `SEC_MAC_LAST);
  assign ev_loaded = (st_q == M_WAIT) && w_done && reload_q && !sig_bad &&
                     idx_q == `SEC_MAC_LAST;

  // ----------------------------------------------------------------------
  // Frame builder
  // ----------------------------------------------------------------------
  // Start bit, two opcode bits, eight address bits, optional data byte
  always @* begin
    frame = {1'b1, `SEC_SER_READ, addr_q, 8'h00};
    nbits = 5'd11;
    rd = 1'b0;
    poll = 1'b0;
    if (reload_q) begin
      frame = {1'b1, `SEC_SER_READ, 5'h00, idx_q, 8'h00};
      rd = 1'b1;
    end else begin
      case (op_q)
        `SEC_OP_READ: rd = 1'b1;
        `SEC_OP_WR_DIS: frame = {1'b1, `SEC_SER_EXT, `SEC_EXT_WR_DIS, 8'h00};
        `SEC_OP_WR_EN: frame = {1'b1, `SEC_SER_EXT, `SEC_EXT_WR_EN, 8'h00};
        `SEC_OP_WRITE: begin
          frame = {1'b1, `SEC_SER_WRITE, addr_q, data_q};
          nbits = 5'd19;
          poll = 1'b1;
        end
        `SEC_OP_WR_ALL: begin
          frame = {1'b1, `SEC_SER_EXT, `SEC_EXT_WR_ALL, data_q};
          nbits = 5'd19;
          poll = 1'b1;
        end
        `SEC_OP_ERASE: begin
          frame = {1'b1, `SEC_SER_ERASE, addr_q, 8'h00};
          poll = 1'b1;
        end
        `SEC_OP_ERASE_ALL: begin
          frame = {1'b1, `SEC_SER_EXT, `SEC_EXT_ERASE_ALL, 8'h00};
          poll = 1'b1;
        end
        default: rd = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  // Reset starts with a reload so busy reads set from the first cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= M_GO;
      busy_q <= 1'b1;
      reload_q <= 1'b1;
      idx_q <= 3'h0;
      mac_addr_q <= 48'h0;
    end else if (clk_en) begin
      case (st_q)
        M_IDLE: begin
          if (go_wr) begin
            busy_q <= 1'b1;
            reload_q <= (wb_dat_i[`SEC_OP_HI:`SEC_OP_LO] == `SEC_OP_RELOAD);
            idx_q <= 3'h0;
            st_q <= M_GO;
          end
        end
        M_GO: st_q <= M_WAIT;
        M_WAIT: begin
          if (w_done) begin
            if (reload_q && idx_q != 3'h0) begin
              mac_addr_q <= {w_rdata, mac_addr_q[47:8]};
            end
            if (ev_done) begin
              busy_q <= 1'b0;
              reload_q <= 1'b0;
              st_q <= M_IDLE;
            end else begin
              idx_q <= idx_q + 3'h1;
              st_q <= M_GO;
            end
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Command and data registers
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= 3'h0;
      addr_q <= 8'h00;
      data_q <= 8'h00;
      tmo_flag_q <= 1'b0;
      loaded_q <= 1'b0;
    end else if (clk_en) begin
      if (cmd_wr && wb_sel_i[3]) begin
        op_q <= wb_dat_i[`SEC_OP_HI:`SEC_OP_LO];
      end
      if (cmd_wr && wb_sel_i[0]) begin
        addr_q <= wb_dat_i[7:0];
      end
      // Read result lands with the edge that drops busy
      if (st_q == M_WAIT && w_done && !reload_q && op_q == `SEC_OP_READ) begin
        data_q <= w_rdata;
      end else if (wr && hit_data && wb_sel_i[0] && !busy_q) begin
        data_q <= wb_dat_i[7:0];
      end
      // Sticky flags, a new event beats a same-cycle clear
      if (w_tmo) begin
        tmo_flag_q <= 1'b1;
      end else if (wr && hit_cmd && wb_sel_i[1] && wb_dat_i[`SEC_TMO_BIT]) begin
        tmo_flag_q <= 1'b0;
      end
      if (ev_loaded) begin
        loaded_q <= 1'b1;
      end else if (wr && hit_cmd && wb_sel_i[1] && wb_dat_i[`SEC_LOADED_BIT]) begin
        loaded_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ists_q <= 3'h0;
      imsk_q <= 3'h0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      ists_q <= (ists_q & ~((wr && hit_ists && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0))
                | {ev_loaded, w_tmo, ev_done};
      if (wr && hit_imsk && wb_sel_i[0]) begin
        imsk_q <= wb_dat_i[2:0];
      end
      // Level output, one cycle behind the status bits
      irq_q <= |(ists_q & imsk_q);
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------------
  // Unmapped addresses still ack, with zero data, so the bus never hangs
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_cmd) begin
      rd_mux[`SEC_BUSY_BIT] = busy_q;
      rd_mux[`SEC_OP_HI:`SEC_OP_LO] = op_q;
      rd_mux[`SEC_TMO_BIT] = tmo_flag_q;
      rd_mux[`SEC_LOADED_BIT] = loaded_q;
      rd_mux[7:0] = addr_q;
    end else if (hit_data) begin
      rd_mux[7:0] = data_q;
    end else if (hit_ists) begin
      rd_mux[2:0] = ists_q;
    end else if (hit_imsk) begin
      rd_mux[2:0] = imsk_q;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (clk_en) begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial link shifter
  // ----------------------------------------------------------------------
  // Time-out only arises on ops that poll for ready after programming
  sec_wire #(
    .TMO_CYC(TMO_CYC)
  ) u_wire (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(w_start),
    .frame(frame),
    .nbits(nbits),
    .rd(rd),
    .poll(poll),
    .done_q(w_done),
    .tmo_q(w_tmo),
    .rdata_q(w_rdata),
    .cs_q(rom_cs),
    .sk_q(rom_clk),
    .dio_o(serial_rom_data_pin_o),
    .dio_oe_q(serial_rom_data_pin_oe),
    .dio_i(serial_rom_data_pin_i)
  );

endmodule // sec_ctrl

// File: bench/sec_ctrl_properties.sv
// Port checker for the serial ROM controller, bound into sec_ctrl.
// Assumes clk_en is held high, so the serial timing runs at full rate.
module sec_ctrl_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link and result
  input wire logic rom_cs,
  input wire logic rom_clk,
  input wire logic serial_rom_data_pin_o,
  input wire logic serial_rom_data_pin_oe,
  input wire logic [47:0] mac_addr_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----
  // Bus answer
  // ----
  // Request not yet answered
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_hole_zero: assert property (req && !wb_we_i && wb_adr_i[7:4] != 4'hB
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // ----
  // Serial link framing
  // ----
  a_clk_framed: assert property (rom_clk |-> rom_cs)
    else $error("serial clock outside frame");
  a_drive_framed: assert property (serial_rom_data_pin_oe |-> rom_cs)
    else $error("data pin driven while deselected");
  a_clk_high: assert property ($rose(rom_clk) |-> rom_clk[*5] ##1 !rom_clk)
    else $error("serial clock high phase not five cycles");
  a_data_setup: assert property ($rose(rom_clk) && serial_rom_data_pin_oe
    |-> $stable(serial_rom_data_pin_o))
    else $error("data moved on rising serial clock");
  // Address byte lands one edge after the frame closes, never from nowhere
  a_mac_framed: assert property ($changed(mac_addr_q) |-> $past(rom_cs, 2))
    else $error("address changed without a frame");
endmodule // sec_ctrl_properties

bind sec_ctrl sec_ctrl_properties i_sec_ctrl_properties (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rom_cs(rom_cs), .rom_clk(rom_clk), .serial_rom_data_pin_o(serial_rom_data_pin_o),
  .serial_rom_data_pin_oe(serial_rom_data_pin_oe), .mac_addr_q(mac_addr_q));

// File: bench/sec_rom_model.sv
// Behavioural serial EEPROM, 256 bytes, write protected at power-up.
// Assumes frames open with a 1 bit, sampled on the rising serial clock.
module sec_rom_model (
  // Busy timer clock
  input wire logic clk_sys,
  // Link
  input wire logic rom_cs,
  input wire logic rom_clk,
  input wire logic pin,
  output wire logic dq_o,
  output wire logic dq_oe,
  // Behaviour
  input wire logic present,
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [18:0] sr;
  logic [8:0] rdat;
  logic [1:0] op;
  logic [7:0] a, d;
  logic en = 0; // Protected until enabled
  logic rd = 0, poll = 0;
  int n = 0, bcnt = 0;
  // Released pin falls to the pull level; a dummy zero leads the read byte
  assign dq_oe = present && rom_cs && (rd || poll);
  assign dq_o = rd ? rdat[8] : (bcnt == 0);
  // Signature, then station address bytes
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    mem[0] = 8'hA5;
    for (int i = 1; i < 7; i++) mem[i] = 8'(16 + i);
  end
  // Busy time after a write-type instruction
  always @(posedge clk_sys) if (bcnt > 0) bcnt <= bcnt - 1;
  // New frame
  always @(posedge rom_cs) begin
    n = 0;
    rd = 0;
  end
  // Shift in, or out for a read
  always @(posedge rom_clk) begin
    if (rom_cs) begin
      poll = 0;
      if (rd) rdat = rdat << 1;
      else begin
        sr = {sr[17:0], pin};
        n++;
        if (n == 11 && sr[9:8] == 2'h2) begin
          rd = 1;
          rdat = {1'b0, mem[sr[7:0]]};
        end
      end
    end
  end
  // Execute at deselect; a poll frame ends the busy report
  always @(negedge rom_cs) begin
    if (n == 0) poll = 0;
    if (present && !rd && (n == 11 || n == 19)) begin
      {op, a} = (n == 19) ? sr[17:8] : sr[9:0];
      d = sr[7:0];
      case (op)
        2'h1: if (en) mem[a] = d;
        2'h3: if (en) mem[a] = 8'hFF;
        default: case (a[7:6])
          2'h0: en = 1'b0;
          2'h3: en = 1'b1;
          2'h1: for (int i = 0; i < 256; i++) if (en) mem[i] = d;
          default: for (int i = 0; i < 256; i++) if (en) mem[i] = 8'hFF;
        endcase
      endcase
      poll = op != 2'h0 || a[7:6] == 2'h1 || a[7:6] == 2'h2;
      bcnt = slow ? 100 : 3;
    end
  end
endmodule // sec_rom_model

// File: bench/sec_ctrl_test.sv
// Self-checking bench for the serial ROM controller with a model EEPROM.
// Assumes a pull-down on the data pin and a shortened time-out count.
module sec_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [2:0] op;
    logic [7:0] a, d, ra, exp;
  } sec_row_t;
  // ----
  // Wiring
  // ----
  logic clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, present = 1, slow = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, q;
  wire [31:0] dat_o;
  wire ack, irq, cs, sk, d_o, d_oe, m_o, m_oe;
  wire [47:0] mac;
  int error_cnt = 0, check_count = 0;
  // Controller wins, else model, else pull-down
  wire pin = d_oe ? d_o : (m_oe ? m_o : 1'b0);
  always #50 clk_sys = ~clk_sys;
  sec_ctrl #(.TMO_CYC(400)) i_sec_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .irq_q(irq), .rom_cs(cs), .rom_clk(sk), .serial_rom_data_pin_o(d_o),
    .serial_rom_data_pin_oe(d_oe), .serial_rom_data_pin_i(pin), .mac_addr_q(mac));
  sec_rom_model i_sec_rom_model (
    .clk_sys(clk_sys), .rom_cs(cs), .rom_clk(sk), .pin(pin), .dq_o(m_o), .dq_oe(m_oe),
    .present(present), .slow(slow));
  // ----
  // Tasks
  // ----
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_up(input string m);
    error_cnt++;
    $display("BAD t=%0t %s", $time, m);
    complete_run();
  endtask
  // One classic cycle; released only at the edge that sees ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk_sys);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= v;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    if (ack !== 1'b1) give_up("no ack");
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(0, 8'hB0, 0);
      n++;
    end while (q[31] !== 1'b0 && n < 1000);
    if (q[31] !== 1'b0) give_up("busy stuck");
  endtask
  task automatic go(input logic [2:0] op, input logic [7:0] a);
    bus(1, 8'hB0, {1'b1, op, 20'h0, a});
    bus(0, 8'hB0, 0);
    chk(q[31], 1); // Busy right after start
  endtask
  task automatic cmd(input logic [2:0] op, input logic [7:0] a);
    go(op, a);
    wait_idle();
  endtask
  // ----
  // Command table: command, then read back one location
  // ----
  sec_row_t rows [8] = '{
    '{3'h3, 8'h20, 8'h5A, 8'h20, 8'hFF},
    '{3'h2, 8'h00, 8'h00, 8'h20, 8'hFF},
    '{3'h3, 8'h20, 8'h5A, 8'h20, 8'h5A},
    '{3'h5, 8'h20, 8'h00, 8'h20, 8'hFF},
    '{3'h4, 8'h00, 8'h3C, 8'h77, 8'h3C},
    '{3'h6, 8'h00, 8'h00, 8'h77, 8'hFF},
    '{3'h1, 8'h00, 8'h00, 8'h20, 8'hFF},
    '{3'h3, 8'h20, 8'h11, 8'h20, 8'hFF}};
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    bus(0, 8'hB0, 0);
    chk(q[31], 1); // Busy during address load
    wait_idle();
    chk(q[8], 1); // Loaded flag
    chk(mac, 48'h161514131211); // Station address
    bus(0, 8'hBC, 0);
    chk(q, 0); // Mask resets clear
    bus(1, 8'h44, 32'hFFFFFFFF);
    bus(0, 8'h44, 0);
    chk(q, 0); // Unmapped place reads zero
    foreach (rows[k]) begin
      bus(1, 8'hB4, {24'h0, rows[k].d});
      cmd(rows[k].op, rows[k].a);
      cmd(3'h0, rows[k].ra);
      bus(0, 8'hB4, 0);
      chk(q, {24'h0, rows[k].exp});
    end
    // Second command while busy is dropped
    go(3'h0, 8'h20);
    bus(1, 8'hB0, {1'b1, 3'h3, 20'h0, 8'h55});
    bus(0, 8'hB0, 0);
    chk(q[7:0], 8'h20); // Address kept while busy
    wait_idle();
    bus(0, 8'hB4, 0);
    chk(q[7:0], 8'hFF); // Read result
    // Missing part: time-out and interrupt
    present <= 0;
    bus(1, 8'hBC, 32'h2);
    go(3'h3, 8'h20);
    repeat (250) @(posedge clk_sys);
    bus(0, 8'hB0, 0);
    chk(q[31], 1); // Still waiting for the part
    wait_idle();
    chk(q[9], 1); // Time-out flag
    chk(irq, 1); // Unmasked event
    bus(1, 8'hBC, 0);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0); // Masked
    bus(1, 8'hBC, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1); // Unmasked again
    bus(1, 8'hB8, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0); // Status cleared by one
    bus(1, 8'hB0, 32'h200);
    bus(0, 8'hB0, 0);
    chk(q[9], 0); // Flag cleared by one
    present <= 1;
    // Reload of a blank part, then of a signed one
    bus(1, 8'hB0, 32'h100);
    cmd(3'h7, 8'h00);
    chk(q[8], 0); // Reload fails without signature
    chk(mac, 48'h161514131211); // Address untouched
    cmd(3'h2, 8'h00);
    slow <= 1;
    bus(1, 8'hB4, 32'hA5);
    cmd(3'h3, 8'h00); // Slow part still finishes
    slow <= 0;
    cmd(3'h7, 8'h00);
    chk(q[8], 1); // Loaded after reload
    chk(mac, 48'hFFFFFFFFFFFF); // Erased bytes loaded
    complete_run();
  end
endmodule // sec_ctrl_test
